// ---- pkg/fast_slew_pkg.sv ----
/*
 * Shared constants for the relaxation oscillator fast slew timer:
 * register offsets, field positions, reset values and counter states.
 * Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
 */
package fast_slew_pkg;

   // Byte offsets within the block's window
   localparam int ADDR_BITS = 8;
   localparam logic [ADDR_BITS-1:0] FAST_SLEW_CONTROL_OFFSET = 8'hA8;
   localparam logic [ADDR_BITS-1:0] SENSE_CONTROL_TWO_OFFSET = 8'hAC;
   localparam logic [ADDR_BITS-1:0] FAST_SLEW_STATUS_OFFSET = 8'hB0;

   // Field layout of fast_slew_control
   localparam int ENABLE_BIT = 0;
   localparam int INTERVAL_LSB = 1;
   localparam int INTERVAL_MSB = 7;
   localparam int INTERVAL_WIDTH = 7;
   localparam int CTRL_WIDTH = 8;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 8'h00;

   // Current-range field, low bits of sense_control_two
   localparam int RANGE_WIDTH = 2;
   localparam logic [RANGE_WIDTH-1:0] RANGE_MAX = 2'h3;
   localparam logic [RANGE_WIDTH-1:0] RANGE_RESET = 2'h0;

   // Status layout: active flag at bit 0, live count above it
   localparam int STATUS_ACTIVE_BIT = 0;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

   // Fast interval sequencing
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_FORCE = 2'b10
   } force_state_t;

endpackage

// ---- core/fast_interval_counter.sv ----
/*
 * Down-counter that times one fast slew interval.
 * Assumes load and abort come from logic on hclk; abort has priority.
 */
`timescale 1ns/1ps
module fast_interval_counter
#(
   parameter int COUNT_WIDTH = 7
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic load,
   input wire logic [COUNT_WIDTH-1:0] load_value,
   input wire logic abort,
   output logic [COUNT_WIDTH-1:0] count,
   output logic busy
);
   import fast_slew_pkg::*;

   generate
      if (COUNT_WIDTH < 1)
      begin : g_bad_width
         $error("fast_interval_counter: COUNT_WIDTH must be at least 1");
      end
   endgenerate

   localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = '0;
   localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = COUNT_WIDTH'(1);

   force_state_t state_reg;
   force_state_t state_next;
   logic [COUNT_WIDTH-1:0] count_reg;
   logic [COUNT_WIDTH-1:0] count_next;

   // Zero load means no interval; last count of one ends it
   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      if (abort)
      begin
         state_next = ST_IDLE;
         count_next = COUNT_ZERO;
      end
      else if (load)
      begin
         count_next = load_value;
         state_next = (load_value == COUNT_ZERO) ? ST_IDLE : ST_FORCE;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               count_next = COUNT_ZERO;
            end
            ST_FORCE:
            begin
               count_next = count_reg - COUNT_ONE;
               if (count_reg == COUNT_ONE)
               begin
                  state_next = ST_IDLE;
               end
            end
            default:
            begin
               state_next = ST_IDLE;
               count_next = COUNT_ZERO;
            end
         endcase
      end
   end

   // State registers, frozen while clk_en is low
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= ST_IDLE;
         count_reg <= '0;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   assign count = count_reg;
   assign busy = (state_reg == ST_FORCE);

endmodule

// ---- core/relaxation_osc_fast_slew_timer.sv ----
/*
 * Fast slew timer for a relaxation oscillator, with its AHB-Lite register slave.
 * Assumes hclk is the internal main oscillator clock and osc_edge_in is the
 * asynchronous relaxation oscillator output; osc_current_range_out feeds the
 * oscillator's charge-current range control.
 */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
// Operation
// - 7-bit interval loads a down-counter on the main clock; forcing lasts while counting.
// - While counting, current-range control is forced to its maximum code 11b.
// - When count ends, the software-programmed range is driven again.
// - Enable low ignores the interval value; no forcing at all.
// - Every oscillator edge while enable is high reloads the counter and repeats the forced interval.
// - Reads of the range field return the programmed value, never forced maximum.
// - Value zero gives no interval; value N gives N main-clock periods.
// - Interval sits in control bits 7:1, enable in bit 0.
module relaxation_osc_fast_slew_timer
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic osc_edge_in,
   output logic [fast_slew_pkg::RANGE_WIDTH-1:0] osc_current_range_out
);
   import fast_slew_pkg::*;

   // Word-aligned match of a bus address against a register offset
   function automatic logic addr_hit(input logic [ADDR_BITS-1:0] addr, input logic [ADDR_BITS-1:0] offset);
      addr_hit = (addr[ADDR_BITS-1:2] == offset[ADDR_BITS-1:2]);
   endfunction

   // Bus data-phase tracking
   logic dph_valid_reg;
   logic dph_valid_next;
   logic dph_write_reg;
   logic dph_write_next;
   logic [ADDR_BITS-1:0] dph_addr_reg;
   logic [ADDR_BITS-1:0] dph_addr_next;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic hreadyout_reg;
   logic hresp_reg;

   // Software registers
   logic [CTRL_WIDTH-1:0] ctrl_reg;
   logic [CTRL_WIDTH-1:0] ctrl_next;
   logic [RANGE_WIDTH-1:0] user_range_reg;
   logic [RANGE_WIDTH-1:0] user_range_next;

   // Oscillator edge synchroniser and output
   logic osc_sync1_reg;
   logic osc_sync2_reg;
   logic osc_sync3_reg;
   logic edge_det;
   logic [RANGE_WIDTH-1:0] range_out_reg;
   logic [RANGE_WIDTH-1:0] range_out_next;

   // Counter hookup
   logic fast_enable;
   logic [INTERVAL_WIDTH-1:0] interval;
   logic reload;
   logic [INTERVAL_WIDTH-1:0] count;
   logic busy;
   logic addr_phase;

   assign fast_enable = ctrl_reg[ENABLE_BIT];
   assign interval = ctrl_reg[INTERVAL_MSB:INTERVAL_LSB];
   assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

   // Register writes land in the data phase; unmapped writes are dropped
   always_comb
   begin
      ctrl_next = ctrl_reg;
      user_range_next = user_range_reg;
      if (dph_valid_reg && dph_write_reg)
      begin
         if (addr_hit(dph_addr_reg, FAST_SLEW_CONTROL_OFFSET))
         begin
            ctrl_next = hwdata[CTRL_WIDTH-1:0];
         end
         if (addr_hit(dph_addr_reg, SENSE_CONTROL_TWO_OFFSET))
         begin
            user_range_next = hwdata[RANGE_WIDTH-1:0];
         end
      end
   end

   // Read data is prepared at the address phase from next values, so a read
   // right after a write already sees the new contents
   always_comb
   begin
      dph_valid_next = addr_phase;
      dph_write_next = addr_phase && hwrite;
      dph_addr_next = haddr[ADDR_BITS-1:0];
      hrdata_next = '0;
      if (addr_phase && !hwrite)
      begin
         if (addr_hit(haddr[ADDR_BITS-1:0], FAST_SLEW_CONTROL_OFFSET))
         begin
            hrdata_next[CTRL_WIDTH-1:0] = ctrl_next;
         end
         else if (addr_hit(haddr[ADDR_BITS-1:0], SENSE_CONTROL_TWO_OFFSET))
         begin
            hrdata_next[RANGE_WIDTH-1:0] = user_range_next;
         end
         else if (addr_hit(haddr[ADDR_BITS-1:0], FAST_SLEW_STATUS_OFFSET))
         begin
            hrdata_next[STATUS_ACTIVE_BIT] = busy;
            hrdata_next[INTERVAL_MSB:INTERVAL_LSB] = count;
         end
      end
   end

   // Bus and register state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_valid_reg <= 1'b0;
         dph_write_reg <= 1'b0;
         dph_addr_reg <= '0;
         hrdata_reg <= '0;
         hreadyout_reg <= 1'b1;
         hresp_reg <= HRESP_OKAY;
         ctrl_reg <= CTRL_RESET;
         user_range_reg <= RANGE_RESET;
      end
      else if (clk_en)
      begin
         dph_valid_reg <= dph_valid_next;
         dph_write_reg <= dph_write_next;
         dph_addr_reg <= dph_addr_next;
         hrdata_reg <= hrdata_next;
         hreadyout_reg <= 1'b1; // No wait states ever
         hresp_reg <= HRESP_OKAY;
         ctrl_reg <= ctrl_next;
         user_range_reg <= user_range_next;
      end
   end

   // Oscillator edge of either polarity, seen only after two flops
   assign edge_det = osc_sync2_reg ^ osc_sync3_reg;
   assign reload = edge_det && fast_enable;

   // Forced maximum while counting, programmed range otherwise
   always_comb
   begin
      range_out_next = busy ? RANGE_MAX : user_range_reg;
   end

   // Synchroniser and output register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         osc_sync1_reg <= 1'b0;
         osc_sync2_reg <= 1'b0;
         osc_sync3_reg <= 1'b0;
         range_out_reg <= RANGE_RESET;
      end
      else if (clk_en)
      begin
         osc_sync1_reg <= osc_edge_in;
         osc_sync2_reg <= osc_sync1_reg;
         osc_sync3_reg <= osc_sync2_reg;
         range_out_reg <= range_out_next;
      end
   end

   // Disabling cancels any running interval at once
   fast_interval_counter #(.COUNT_WIDTH(INTERVAL_WIDTH)) u_counter
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_en(clk_en),
      .load(reload),
      .load_value(interval),
      .abort(!fast_enable),
      .count(count),
      .busy(busy)
   );

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign osc_current_range_out = range_out_reg;

   // Checks on the timer and register behaviour
   AST_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && reload && interval != '0 |=> busy && count == $past(interval))
      else $error("counter not loaded from interval on oscillator edge");
   AST_FORCE_MAX: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && busy |=> osc_current_range_out == RANGE_MAX)
      else $error("range not forced to maximum during fast interval");
   AST_RESTORE: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && !busy ##1 clk_en && !busy |=> osc_current_range_out == $past(user_range_reg))
      else $error("programmed range not restored after interval");
   AST_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && !fast_enable |=> !busy)
      else $error("forcing while fast slew disabled");
   AST_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && busy && reload |=> count == $past(interval))
      else $error("oscillator edge did not reload running counter");
   AST_READ_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
      dph_valid_reg && !dph_write_reg && addr_hit(dph_addr_reg, SENSE_CONTROL_TWO_OFFSET)
      |-> hrdata[RANGE_WIDTH-1:0] == user_range_reg)
      else $error("range read did not return programmed value");
   AST_ZERO_INTERVAL: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && reload && interval == '0 |=> !busy)
      else $error("zero interval produced forcing");
   AST_COUNT_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && busy && !reload && fast_enable && count > 7'h1 |=> busy && count == $past(count) - 7'h1)
      else $error("interval counter did not step by one");
   AST_ONE_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && reload && interval == 7'h01 ##1 clk_en && !reload |=> !busy)
      else $error("interval of one did not last exactly one period");
   AST_CTRL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && dph_valid_reg && dph_write_reg && addr_hit(dph_addr_reg, FAST_SLEW_CONTROL_OFFSET)
      |=> fast_enable == $past(hwdata[ENABLE_BIT]) && interval == $past(hwdata[INTERVAL_MSB:INTERVAL_LSB]))
      else $error("control write fields misplaced");
   AST_SYNC_PATH: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(clk_en) && edge_det |-> osc_sync2_reg != $past(osc_sync2_reg))
      else $error("edge detected without synchronised change");

   COV_FORCED: cover property (@(posedge hclk) disable iff (!hresetn) busy && reload);
   COV_EXPIRE: cover property (@(posedge hclk) disable iff (!hresetn) busy ##1 !busy);
   COV_RANGE_READ: cover property (@(posedge hclk) disable iff (!hresetn)
      dph_valid_reg && !dph_write_reg && addr_hit(dph_addr_reg, SENSE_CONTROL_TWO_OFFSET) && busy);
   COV_DISABLE_MID: cover property (@(posedge hclk) disable iff (!hresetn) busy && !fast_enable);

endmodule

// ---- bench/relax_osc_model.sv ----
/*
 * Behavioural relaxation oscillator for the fast slew timer bench.
 * Assumes the bench asks for each transition by calling transition();
 * the output then changes after a lag unrelated to the bus clock phase.
 */
`timescale 1ns/1ps
module relax_osc_model
#(
   parameter int LAG_NS = 7
)
(
   output logic osc_edge_in
);
   // Oscillator output idles low until the first transition
   initial osc_edge_in = 1'b0;

   // One transition, rising or falling; larger lag models a slow edge
   task transition();
      #(LAG_NS) osc_edge_in = ~osc_edge_in;
   endtask
endmodule

// ---- bench/relaxation_osc_fast_slew_timer_tb.sv ----
/*
 * Self-checking bench for the relaxation oscillator fast slew timer.
 * Assumes a single AHB-Lite master with hready tied to hreadyout and the
 * oscillator model above on the edge input.
 */
`timescale 1ns/1ps
module relaxation_osc_fast_slew_timer_tb;
   import fast_slew_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic clk_en = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic [31:0] rd_s;
   logic hreadyout;
   logic hresp;
   logic rdy_s;
   logic osc_edge_in;
   logic [1:0] range_out;
   int miscompares = 0;
   int checks = 0;

   // 25 MHz bus clock
   always #20 hclk = ~hclk;

   // Edge-sampled bus answers, so the master never races the slave's update
   always @(posedge hclk)
   begin
      rd_s <= hrdata;
      rdy_s <= hreadyout;
   end

   relaxation_osc_fast_slew_timer i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_edge_in(osc_edge_in),
      .osc_current_range_out(range_out));

   relax_osc_model #(.LAG_NS(7)) i_osc (.osc_edge_in(osc_edge_in));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One single transfer; address held until hready, data held until hready
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do
      begin
         @(posedge hclk);
         #1;
      end
      while (rdy_s !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do
      begin
         @(posedge hclk);
         #1;
      end
      while (rdy_s !== 1'b1);
      r = rd_s;
      check(hresp, HRESP_OKAY);
   endtask

   // Cycles spent at the forced code after the next oscillator edge
   task measure(output logic [31:0] n);
      int i;
      n = 32'h0;
      for (i = 0; i < 20 && range_out !== RANGE_MAX; i++) @(negedge hclk);
      while (range_out === RANGE_MAX && n < 300)
      begin
         n++;
         @(negedge hclk);
      end
   endtask

   task test_regs();
      logic [31:0] r;
      check(range_out, RANGE_RESET);
      bus(1'b0, FAST_SLEW_CONTROL_OFFSET, 32'h0, r);
      check(r, CTRL_RESET);
      bus(1'b1, FAST_SLEW_CONTROL_OFFSET, 32'hA5, r);
      bus(1'b0, FAST_SLEW_CONTROL_OFFSET, 32'h0, r);
      check(r, 32'hA5);
      bus(1'b0, 32'h10, 32'h0, r); check(r, 32'h0);
   endtask

   // Forced length equals the interval; read-back keeps the programmed range
   task test_interval();
      logic [31:0] r;
      logic [31:0] s;
      logic [31:0] n;
      logic [6:0] tbl [3];
      tbl = '{7'h01, 7'h02, 7'h7F};
      bus(1'b1, SENSE_CONTROL_TWO_OFFSET, 32'h1, r);
      foreach (tbl[k])
      begin
         bus(1'b1, FAST_SLEW_CONTROL_OFFSET, {24'h0, tbl[k], 1'b1}, r);
         fork
            measure(n);
            begin
               @(posedge hclk);
               i_osc.transition();
               repeat (8) @(posedge hclk);
               bus(1'b0, SENSE_CONTROL_TWO_OFFSET, 32'h0, r);
               // Status taken eleven edges after the stimulus edge: count has stepped seven times
               bus(1'b0, FAST_SLEW_STATUS_OFFSET, 32'h0, s);
            end
         join
         check(n, {25'h0, tbl[k]});
         check(r, 32'h1);
         check(s, (tbl[k] > 7'h7) ? {24'h0, tbl[k] - 7'h7, 1'b1} : 32'h0);
         check(range_out, 2'h1);
      end
   endtask

   // Zero interval and disabled enable never force
   task test_no_force();
      logic [31:0] r;
      logic [31:0] n;
      bus(1'b1, FAST_SLEW_CONTROL_OFFSET, 32'h01, r);
      fork measure(n); i_osc.transition(); join
      check(n, 32'h0);
      bus(1'b1, FAST_SLEW_CONTROL_OFFSET, {24'h0, 7'h05, 1'b0}, r);
      fork measure(n); i_osc.transition(); join
      check(n, 32'h0);
   endtask

   // Edge three cycles into an interval of four restarts it: seven forced cycles
   task test_reload();
      logic [31:0] r;
      logic [31:0] n;
      bus(1'b1, FAST_SLEW_CONTROL_OFFSET, {24'h0, 7'h04, 1'b1}, r);
      fork
         measure(n);
         begin
            @(posedge hclk);
            i_osc.transition();
            repeat (3) @(posedge hclk);
            i_osc.transition();
         end
      join
      check(n, 32'h7);
   endtask

   // Hang guard
   initial
   begin
      #(40 * 20000);
      miscompares++;
      complete_run();
   end

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      test_regs();
      test_interval();
      test_no_force();
      test_reload();
      complete_run();
   end
endmodule
